/* File: rtl/pfc_top.sv */
// pause flow control: xoff/xon insertion, rx pause filtering, tx hold
// assumes a tx mac that sends the offered control frame and reports
// frame activity, and an rx parser that reports each frame at its end
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"

module pfc_top #(
  parameter int NUM_CLASSES = 1,
  parameter bit DROP_BAD_STD = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client pause control
  input wire logic [NUM_CLASSES-1:0] pause_insert_tx,
  output logic [NUM_CLASSES-1:0] pause_receive_rx,
  output logic tx_client_ready,
  // tx mac control frame offer
  input wire logic tx_frm_busy,
  input wire logic tx_ctl_ready,
  output logic tx_ctl_valid,
  output logic tx_ctl_xoff,
  output logic [15:0] tx_ctl_type,
  output logic [15:0] tx_ctl_opcode,
  output logic [7:0] tx_ctl_cls,
  output logic [15:0] tx_ctl_time,
  // rx frame report
  input wire logic rx_frm_done,
  input wire logic [47:0] rx_frm_da,
  input wire logic [15:0] rx_frm_type,
  input wire logic [15:0] rx_frm_opcode,
  input wire logic [7:0] rx_frm_cls_en,
  input wire logic [127:0] rx_frm_times,
  input wire logic rx_frm_runt,
  input wire logic rx_frm_fcs_err,
  output logic rx_frm_deliver,
  output logic rx_frm_drop
);

  // quantum length in ps, rounded up to whole clock cycles
  localparam int QUANTUM_PS = `PFC_QUANTUM_BITS * 1000 / `PFC_LINK_GBPS;
  localparam int QCYC_RAW = (QUANTUM_PS + `PFC_CLK_PS - 1) / `PFC_CLK_PS;
  localparam int QCYC_INT = (QCYC_RAW < 1) ? 1 : QCYC_RAW;
  localparam logic [7:0] QCYC_LAST = 8'(QCYC_INT - 1);

  if (NUM_CLASSES < 1 || NUM_CLASSES > `PFC_MAX_CLASSES)
  begin : g_bad_classes
    $error("NUM_CLASSES must lie between 1 and 8");
  end
  if (QCYC_INT > 256)
  begin : g_bad_quantum
    $error("quantum divider too long for its counter");
  end

  localparam pfc_pkg::pfc_state_t RST_STATE = '{
    st: pfc_pkg::PFC_IDLE,
    ctrl: `PFC_CTRL_RST,
    obey: `PFC_OBEY_RST,
    tx_en: `PFC_TXEN_RST,
    quanta: `PFC_QUANTA_RST,
    holdoff: `PFC_HOLDOFF_RST,
    default: '0
  };

  pfc_pkg::pfc_state_t r;
  pfc_pkg::pfc_state_t n;
  logic [7:0] ins_v;
  logic [11:0] widx;
  logic proc_en;
  logic prio;
  logic accepting;
  logic rx_is_pause;
  logic rx_addr_ok;
  logic rx_bad;
  logic rx_act;
  logic tx_want_hold;

  // request width follows the class count; unused lanes stay low
  always_comb
  begin
    ins_v = '0;
    ins_v[NUM_CLASSES-1:0] = pause_insert_tx;
  end

  assign widx = paddr[13:2];
  assign proc_en = r.ctrl[`PFC_CTRL_PROC];
  assign prio = r.ctrl[`PFC_CTRL_PRIO];
  assign accepting = (r.st == pfc_pkg::PFC_OFFER) && tx_ctl_ready;

  // pause frame: ethertype and the opcode of the active mode
  assign rx_is_pause = (rx_frm_type == `PFC_ETYPE) &&
    (rx_frm_opcode == (prio ? `PFC_OPC_PRIO : `PFC_OPC_STD));
  // reserved multicast or this mode's pair
  assign rx_addr_ok = (rx_frm_da == `PFC_MCAST_DA) ||
    (rx_frm_da == (prio ? {r.pr_hi, r.pr_lo} : {r.std_hi, r.std_lo}));
  // standard-mode runts and crc failures never act
  assign rx_bad = DROP_BAD_STD && !prio && (rx_frm_runt || rx_frm_fcs_err);
  // processing gate; forwarding plays no part here
  assign rx_act = rx_frm_done && proc_en && rx_is_pause && rx_addr_ok &&
    !rx_bad;

  always_comb
  begin
    n = r;
    n.rx_deliver = 1'b0;
    n.rx_drop = 1'b0;

    // apb: read data and error latched in setup, shown in access
    if (psel && !penable)
    begin
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (widx == `PFC_IDX_CTRL)
        n.prdata[3:0] = r.ctrl;
      else if (widx == `PFC_IDX_OBEY)
        n.prdata[0] = r.obey;
      else if (widx == `PFC_IDX_TXEN)
        n.prdata[7:0] = r.tx_en;
      else if (widx == `PFC_IDX_QUANTA)
        n.prdata = {r.holdoff, r.quanta};
      else if (widx == `PFC_IDX_STATUS)
        n.prdata = {6'h00, r.st, r.xon_pend, r.xoff_pend, r.rx_match};
      else if (widx == `PFC_IDX_ADDR_LOW)
        n.prdata = r.std_lo;
      else if (widx == `PFC_IDX_ADDR_HIGH)
        n.prdata[15:0] = r.std_hi;
      else if (widx == `PFC_IDX_PRIO_LO)
        n.prdata = r.pr_lo;
      else if (widx == `PFC_IDX_PRIO_HI)
        n.prdata[15:0] = r.pr_hi;
      else
        n.pslverr = 1'b1;
    end
    if (psel && penable && pwrite && !r.pslverr)
    begin
      if (widx == `PFC_IDX_CTRL)
        n.ctrl = pwdata[3:0];
      else if (widx == `PFC_IDX_OBEY)
        n.obey = pwdata[0];
      else if (widx == `PFC_IDX_TXEN)
        n.tx_en = pwdata[7:0];
      else if (widx == `PFC_IDX_QUANTA)
      begin
        n.quanta = pwdata[15:0];
        n.holdoff = pwdata[31:16];
      end
      else if (widx == `PFC_IDX_ADDR_LOW)
        n.std_lo = pwdata;
      else if (widx == `PFC_IDX_ADDR_HIGH)
        n.std_hi = pwdata[15:0];
      else if (widx == `PFC_IDX_PRIO_LO)
        n.pr_lo = pwdata;
      else if (widx == `PFC_IDX_PRIO_HI)
        n.pr_hi = pwdata[15:0];
    end

    // quantum tick divider
    if (r.qdiv == QCYC_LAST)
    begin
      n.qdiv = '0;
      n.qtick = 1'b1;
    end
    else
    begin
      n.qdiv = r.qdiv + 8'h01;
      n.qtick = 1'b0;
    end

    // per-class request tracking; clears first so a new event wins
    for (int i = 0; i < `PFC_MAX_CLASSES; i++)
    begin
      if (accepting && r.ofr_cls[i] && r.ofr_xoff)
      begin
        n.xoff_pend[i] = 1'b0;
        n.hold_cnt[i] = r.holdoff;
      end
      else if (r.qtick && r.hold_cnt[i] != '0)
        n.hold_cnt[i] = r.hold_cnt[i] - 16'h0001;
      if (accepting && r.ofr_cls[i] && !r.ofr_xoff)
        n.xon_pend[i] = 1'b0;
      if (i < NUM_CLASSES && (prio || i == 0) && r.tx_en[i])
      begin
        if (ins_v[i] && !r.ins_prev[i])
        begin
          n.xoff_pend[i] = 1'b1;
          n.xon_pend[i] = 1'b0;
        end
        else if (!ins_v[i] && r.ins_prev[i])
        begin
          n.xon_pend[i] = 1'b1;
          n.xoff_pend[i] = 1'b0;
        end
        else if (r.ctrl[`PFC_CTRL_RETX] && ins_v[i] && r.ins_prev[i] &&
                 r.hold_cnt[i] == '0 && !r.xoff_pend[i] &&
                 !(r.st == pfc_pkg::PFC_OFFER && r.ofr_cls[i]))
          n.xoff_pend[i] = 1'b1; // hold-off lapsed, send again
      end
    end
    n.ins_prev = ins_v;

    // control frame insertion between client frames
    case (r.st)
      pfc_pkg::PFC_IDLE:
      begin
        if (|(r.xoff_pend | r.xon_pend))
          n.st = pfc_pkg::PFC_WAIT;
      end
      pfc_pkg::PFC_WAIT:
      begin
        // never cut into a frame already on the wire
        if (!tx_frm_busy)
        begin
          n.st = pfc_pkg::PFC_OFFER;
          n.ofr_opc = prio ? `PFC_OPC_PRIO : `PFC_OPC_STD;
          if (|r.xoff_pend)
          begin
            n.ofr_xoff = 1'b1;
            n.ofr_cls = r.xoff_pend;
            n.ofr_time = r.quanta;
          end
          else if (|r.xon_pend)
          begin
            n.ofr_xoff = 1'b0;
            n.ofr_cls = r.xon_pend;
            n.ofr_time = '0;
          end
          else
            n.st = pfc_pkg::PFC_IDLE;
        end
      end
      pfc_pkg::PFC_OFFER:
      begin
        if (tx_ctl_ready)
          n.st = pfc_pkg::PFC_IDLE;
      end
      default:
        n.st = pfc_pkg::PFC_IDLE;
    endcase

    // rx delivery: only matching pause frames feel the forward bit
    if (rx_frm_done)
    begin
      if (rx_is_pause && rx_addr_ok)
      begin
        // drop unless processing and forwarding both on
        n.rx_deliver = proc_en && r.ctrl[`PFC_CTRL_FWD];
        n.rx_drop = !(proc_en && r.ctrl[`PFC_CTRL_FWD]);
      end
      else
        n.rx_deliver = 1'b1;
    end

    // pause timers; a new quanta value overrides the running one
    for (int i = 0; i < `PFC_MAX_CLASSES; i++)
    begin
      if (r.qtick && r.rx_tmr[i] != '0)
        n.rx_tmr[i] = r.rx_tmr[i] - 16'h0001;
      // same clock on both sides, so the request is a plain pulse
      if (rx_act && i < NUM_CLASSES &&
          (prio ? rx_frm_cls_en[i] : (i == 0)))
        n.rx_tmr[i] = rx_frm_times[i*`PFC_TIME_W +: `PFC_TIME_W];
      n.rx_match[i] = (n.rx_tmr[i] != '0);
    end

    // standard mode hold, taken only at a frame boundary
    tx_want_hold = !prio && r.obey && (n.rx_tmr[0] != '0);
    n.hold = tx_want_hold && (r.hold || !tx_frm_busy);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      r <= RST_STATE;
    else
      r <= n;
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign pause_receive_rx = r.rx_match[NUM_CLASSES-1:0];
  // in priority mode the client throttles itself from the match output
  assign tx_client_ready = !r.hold && (r.st != pfc_pkg::PFC_OFFER);
  assign tx_ctl_valid = (r.st == pfc_pkg::PFC_OFFER);
  assign tx_ctl_xoff = r.ofr_xoff;
  assign tx_ctl_type = `PFC_ETYPE;
  assign tx_ctl_opcode = r.ofr_opc;
  assign tx_ctl_cls = r.ofr_cls;
  assign tx_ctl_time = r.ofr_time;
  assign rx_frm_deliver = r.rx_deliver;
  assign rx_frm_drop = r.rx_drop;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_offer_wait;
    tx_ctl_valid && !tx_ctl_ready;
  endsequence

  sequence s_offer_held;
    tx_ctl_valid && $stable(tx_ctl_cls) && $stable(tx_ctl_xoff);
  endsequence

  xoff_rise_a: assert property (
    $rose(pause_insert_tx[0]) && r.tx_en[0] |=> r.xoff_pend[0])
    else $error("xoff not requested on rising level");

  xon_fall_a: assert property (
    $fell(pause_insert_tx[0]) && r.tx_en[0] |=> r.xon_pend[0])
    else $error("xon not requested on falling level");

  offer_gap_a: assert property (
    $rose(tx_ctl_valid) |-> !$past(tx_frm_busy))
    else $error("control frame offered during a frame");

  offer_hold_a: assert property (
    s_offer_wait |=> s_offer_held)
    else $error("offer changed before it was taken");

  proc_off_a: assert property (
    !proc_en && r.rx_tmr[0] == '0 |=> r.rx_tmr[0] == '0)
    else $error("pause timer loaded with processing off");

  fwd_off_a: assert property (
    rx_frm_done && rx_is_pause && rx_addr_ok && !r.ctrl[`PFC_CTRL_FWD]
    |=> rx_frm_drop && !rx_frm_deliver)
    else $error("matching pause frame not dropped");

  nomatch_a: assert property (
    rx_frm_done && rx_is_pause && !rx_addr_ok |=> rx_frm_deliver)
    else $error("non-matching pause frame not delivered");

  match_out_a: assert property (
    rx_act && !prio && rx_frm_times[15:0] != '0 |=> pause_receive_rx[0])
    else $error("match output missing after accepted pause");

  bad_frame_a: assert property (
    rx_frm_done && rx_bad && r.rx_tmr[0] == '0 |=> !pause_receive_rx[0])
    else $error("bad standard pause frame acted on");

  obey_off_a: assert property (
    !r.obey |=> !r.hold)
    else $error("transmit held while obey is off");

  hold_ready_a: assert property (
    !prio && r.obey && r.rx_tmr[0] > 16'h0001 && !tx_frm_busy &&
    !rx_frm_done |=> !tx_client_ready)
    else $error("client not blocked while paused");

endmodule : pfc_top

`default_nettype wire

/* File: rtl/pfc_defs.svh */
// constants for the pause flow-control block
// assumes a single core clock and an apb register port
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// register indices; byte address is four times the index
`define PFC_IDX_CTRL 12'h700
`define PFC_IDX_OBEY 12'h701
`define PFC_IDX_TXEN 12'h702
`define PFC_IDX_QUANTA 12'h703
`define PFC_IDX_STATUS 12'h704
`define PFC_IDX_ADDR_LOW 12'h707
`define PFC_IDX_ADDR_HIGH 12'h708
`define PFC_IDX_PRIO_LO 12'h709
`define PFC_IDX_PRIO_HI 12'h70a

// control register fields
`define PFC_CTRL_PROC 0
`define PFC_CTRL_FWD 1
`define PFC_CTRL_RETX 2
`define PFC_CTRL_PRIO 3
`define PFC_CTRL_RST 4'h1
`define PFC_OBEY_RST 1'h1
`define PFC_TXEN_RST 8'hff
`define PFC_QUANTA_RST 16'hffff
`define PFC_HOLDOFF_RST 16'h8000

// frame fields
`define PFC_ETYPE 16'h8808
`define PFC_OPC_STD 16'h0001
`define PFC_OPC_PRIO 16'h0101
`define PFC_MCAST_DA 48'h0180c2000001
`define PFC_MAX_CLASSES 8
`define PFC_TIME_W 16

// timing: one quantum is 512 bit times on a 40 Gb/s link
`define PFC_QUANTUM_BITS 512
`define PFC_LINK_GBPS 40
`define PFC_CLK_PS 25000

`endif

/* File: rtl/pfc_pkg.sv */
// types for the pause flow-control block
// assumes pfc_defs.svh is on the include path
`include "pfc_defs.svh"

package pfc_pkg;

  typedef enum logic [1:0] {
    PFC_IDLE = 2'h0,
    PFC_WAIT = 2'h1,
    PFC_OFFER = 2'h3
  } pfc_tx_st_t;

  typedef struct packed {
    pfc_tx_st_t st;
    logic [31:0] prdata;
    logic pslverr;
    logic [3:0] ctrl;
    logic obey;
    logic [7:0] tx_en;
    logic [15:0] quanta;
    logic [15:0] holdoff;
    logic [31:0] std_lo;
    logic [15:0] std_hi;
    logic [31:0] pr_lo;
    logic [15:0] pr_hi;
    logic [7:0] ins_prev;
    logic [7:0] xoff_pend;
    logic [7:0] xon_pend;
    logic [7:0][15:0] hold_cnt;
    logic [7:0][15:0] rx_tmr;
    logic [7:0] qdiv;
    logic qtick;
    logic [7:0] ofr_cls;
    logic ofr_xoff;
    logic [15:0] ofr_time;
    logic [15:0] ofr_opc;
    logic rx_deliver;
    logic rx_drop;
    logic [7:0] rx_match;
    logic hold;
  } pfc_state_t;

endpackage : pfc_pkg

/* File: dv/pfc_mac_model.sv */
// tx mac model: takes offered control frames and sends client frames
// assumes the bench pulses frm_start and sets stall for slow answers
`timescale 1ns/1ps
`default_nettype none

module pfc_mac_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench control
  input wire logic stall,
  input wire logic frm_start,
  // control frame offer
  input wire logic tx_ctl_valid,
  input wire logic tx_ctl_xoff,
  input wire logic [15:0] ctl_type,
  input wire logic [15:0] ctl_opc,
  input wire logic [7:0] ctl_cls,
  input wire logic [15:0] ctl_time,
  output logic tx_ctl_ready,
  output logic tx_frm_busy
);
  int n_frm;
  int busy_cnt;
  logic [56:0] last;

  // a stalled mac leaves the offer standing
  assign tx_ctl_ready = !stall;
  assign tx_frm_busy = busy_cnt != 0;

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      n_frm <= 0;
      busy_cnt <= 0;
      last <= '0;
    end
    else
    begin
      if (frm_start)
        busy_cnt <= 10;
      else if (busy_cnt != 0)
        busy_cnt <= busy_cnt - 1;
      if (tx_ctl_valid && tx_ctl_ready)
      begin
        n_frm <= n_frm + 1;
        last <= {tx_ctl_xoff, ctl_cls, ctl_time, ctl_type, ctl_opc};
      end
    end
  end
endmodule : pfc_mac_model
`default_nettype wire

/* File: dv/pause_flow_control_test.sv */
// bench for pause flow control: apb access, rx reports, tx offers
// assumes pfc_top and pfc_mac_model; std mode uses class 0
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"

module pause_flow_control_test;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr, ctype, copc, ctime, rx_opc, rx_type;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ins, rcv, ccls, rx_cls;
  logic cready, cvalid, cxoff, cbusy, rdy, stall, fstart;
  logic done, runt, dlv, drp, fcs;
  logic [47:0] rx_da;
  int err_total, n_tests, prev;
  int cyc = 0;
  localparam logic [47:0] DA = 48'h0e0f0a0b0c0d;

  pfc_top #(.NUM_CLASSES(8), .DROP_BAD_STD(1'b1)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pause_insert_tx(ins),
    .pause_receive_rx(rcv), .tx_client_ready(cready),
    .tx_frm_busy(cbusy), .tx_ctl_ready(rdy), .tx_ctl_valid(cvalid),
    .tx_ctl_xoff(cxoff), .tx_ctl_type(ctype), .tx_ctl_opcode(copc),
    .tx_ctl_cls(ccls), .tx_ctl_time(ctime), .rx_frm_done(done),
    .rx_frm_da(rx_da), .rx_frm_type(rx_type), .rx_frm_opcode(rx_opc),
    .rx_frm_cls_en(rx_cls), .rx_frm_times({8{16'h0008}}),
    .rx_frm_runt(runt), .rx_frm_fcs_err(fcs), .rx_frm_deliver(dlv),
    .rx_frm_drop(drp));

  pfc_mac_model mac (
    .core_clk(core_clk), .rst_n(rst_n), .stall(stall),
    .frm_start(fstart), .tx_ctl_valid(cvalid), .tx_ctl_xoff(cxoff),
    .ctl_type(ctype), .ctl_opc(copc), .ctl_cls(ccls), .ctl_time(ctime),
    .tx_ctl_ready(rdy), .tx_frm_busy(cbusy));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // run should end near 430 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // exp is {deliver, drop, client ready, match vector}
  task rx(input logic [47:0] da, input logic [15:0] opc,
    input logic [7:0] cls, input logic bad, input logic [10:0] exp);
    @(posedge core_clk);
    done <= 1'b1;
    rx_da <= da;
    rx_opc <= opc;
    rx_cls <= cls;
    runt <= bad;
    @(posedge core_clk);
    done <= 1'b0;
    #1;
    chk({dlv, drp, cready, rcv}, exp);
    repeat (5) @(posedge core_clk);
    #1;
    chk({cready, rcv}, exp[8:0]);
    repeat (7) @(posedge core_clk);
    chk({cready, rcv}, 9'h100);
  endtask : rx

  task wait_frm();
    int n;
    n = 0;
    while (mac.n_frm == prev && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 40, 1'b1);
    prev = mac.n_frm;
  endtask : wait_frm

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, ins} = '0;
    {stall, fstart, done, rx_da, rx_opc, rx_cls, runt, fcs} = '0;
    rx_type = `PFC_ETYPE;
    err_total = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, `PFC_IDX_CTRL, 0);
    chk(rd, 32'h1);
    apb(0, `PFC_IDX_OBEY, 0);
    chk(rd[0], 1'b1);
    apb(1, 12'h7ff, 32'h5);
    chk(err, 1'b1);
    apb(1, `PFC_IDX_ADDR_LOW, 32'h0a0b0c0d);
    apb(1, `PFC_IDX_ADDR_HIGH, 32'h0e0f);
    apb(0, `PFC_IDX_ADDR_LOW, 0);
    chk(rd, 32'h0a0b0c0d);
    $display("test registers done");
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b010, 8'h01});
    rx(DA ^ 48'h1, `PFC_OPC_STD, 0, 0, {3'b101, 8'h00});
    rx(DA, `PFC_OPC_STD, 0, 1, {3'b011, 8'h00});
    fcs <= 1'b1;
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b011, 8'h00});
    fcs <= 1'b0;
    rx_type <= 16'h0800;
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b101, 8'h00});
    rx_type <= `PFC_ETYPE;
    apb(1, `PFC_IDX_CTRL, 32'h3);
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b100, 8'h01});
    apb(1, `PFC_IDX_CTRL, 32'h0);
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b011, 8'h00});
    apb(1, `PFC_IDX_CTRL, 32'h1);
    apb(1, `PFC_IDX_OBEY, 32'h0);
    rx(DA, `PFC_OPC_STD, 0, 0, {3'b011, 8'h01});
    apb(1, `PFC_IDX_ADDR_LOW, 32'hffffffff);
    apb(1, `PFC_IDX_ADDR_HIGH, 32'hffff);
    rx('1, `PFC_OPC_STD, 0, 0, {3'b011, 8'h01});
    apb(1, `PFC_IDX_OBEY, 32'h1);
    apb(1, `PFC_IDX_CTRL, 32'h9);
    rx(`PFC_MCAST_DA, `PFC_OPC_PRIO, 8'h04, 0, {3'b011, 8'h04});
    apb(1, `PFC_IDX_PRIO_LO, 32'h11223344);
    apb(1, `PFC_IDX_PRIO_HI, 32'h5566);
    rx(48'h556611223344, `PFC_OPC_PRIO, 8'h02, 0, {3'b011, 8'h02});
    rx('1, `PFC_OPC_PRIO, 8'h02, 0, {3'b101, 8'h00});
    apb(1, `PFC_IDX_CTRL, 32'h1);
    $display("test rx done");
    prev = mac.n_frm;
    fstart <= 1'b1;
    @(posedge core_clk);
    fstart <= 1'b0;
    ins <= 8'h01;
    repeat (5) @(posedge core_clk);
    chk(mac.n_frm, prev);
    wait_frm();
    chk(mac.last, {9'h101, 16'hffff, `PFC_ETYPE, `PFC_OPC_STD});
    stall <= 1'b1;
    ins <= 8'h00;
    repeat (8) @(posedge core_clk);
    chk(cvalid, 1'b1);
    stall <= 1'b0;
    wait_frm();
    chk(mac.last[56:32], {9'h001, 16'h0000});
    apb(1, `PFC_IDX_TXEN, 32'hfe);
    ins <= 8'h01;
    repeat (20) @(posedge core_clk);
    chk(mac.n_frm, prev);
    ins <= 8'h00;
    apb(1, `PFC_IDX_TXEN, 32'hff);
    apb(1, `PFC_IDX_QUANTA, 32'h00100020);
    apb(1, `PFC_IDX_CTRL, 32'h5);
    ins <= 8'h01;
    repeat (100) @(posedge core_clk);
    chk(mac.n_frm - prev >= 3, 1'b1);
    chk(mac.n_frm - prev <= 7, 1'b1);
    ins <= 8'h00;
    repeat (30) @(posedge core_clk);
    prev = mac.n_frm;
    apb(1, `PFC_IDX_CTRL, 32'h9);
    ins <= 8'h08;
    wait_frm();
    chk({mac.last[55:48], mac.last[15:0]}, {8'h08, `PFC_OPC_PRIO});
    $display("test tx done");
    end_of_test();
  end
endmodule : pause_flow_control_test
`default_nettype wire
